// *** rtl/slw_top.sv ***
// start lockout timer and serial watchdog with a wishbone slave
//
// Behaviour
// - start interval is off (zero) or 1..999 seconds, off after reset
// - starts from serial or two-wire input refused while interval runs
// - interval timing begins at any stop, ramped or coasting
// - jog commands bypass the start interval lockout
// - direction reversal waits for the interval before restarting
// - watchdog time is off or 1..5 seconds; off disables supervision
// - watchdog action 1, 2 or 3, default 1; 1 only flags error
// - action 2 flags error, ramps down, or coasts when ramp time off
// - action 3 flags error and disables drive at once, motor coasts
// - comm timeout error clears itself when valid telegrams resume
//
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "slw_params.svh"
module slw_top #(
	parameter int TICK_CYCLES = `SLW_TICK_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic din_start_i,
	input wire logic telegram_ok_i,
	output logic motor_run_o,
	output logic motor_dir_o,
	output logic jog_o,
	output logic ramp_stop_o,
	output logic coast_stop_o,
	output logic emerg_disable_o,
	output logic comm_timeout_error_o,
	output logic start_locked_o,
	output logic irq_o
);
	// the tick must drop between pulses for the counters to see single steps
	if (TICK_CYCLES < 2) begin : g_bad_tick
		$error("TICK_CYCLES must be at least 2");
	end

	logic [9:0] start_interval_time_q;
	logic [15:0] decel_ramp_time_q;
	logic [2:0] comm_watchdog_time_q;
	logic [1:0] watchdog_action_select_q;
	logic [31:0] tick_cnt_q;
	logic tick_q;
	logic [9:0] intv_cnt_q;
	logic [2:0] wd_cnt_q;
	logic [2:0] irq_stat_q;
	logic [2:0] irq_en_q;
	logic [2:0] irq_clr;
	logic [2:0] irq_set;
	logic din_s1_q, din_s2_q, din_s3_q;
	logic tel_s1_q, tel_s2_q, tel_s3_q;
	slw_pkg::slw_state_t state_q;

	wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wb_wr = wb_req && wb_we_i;
	wire wr_cmd = wb_wr && wb_adr_i == `SLW_ADDR_CMD && wb_sel_i[0];
	wire cmd_start = wr_cmd && wb_dat_i[`SLW_CMD_START];
	wire cmd_stop = wr_cmd && wb_dat_i[`SLW_CMD_STOP];
	wire cmd_jog = wr_cmd && wb_dat_i[`SLW_CMD_JOG];
	wire cmd_rev = wr_cmd && wb_dat_i[`SLW_CMD_REV];
	wire din_rise = din_s2_q && !din_s3_q;
	wire din_fall = !din_s2_q && din_s3_q;
	wire tel_pulse = tel_s2_q && !tel_s3_q;
	wire locked = start_interval_time_q != 10'h000 && intv_cnt_q < start_interval_time_q;
	wire wd_on = comm_watchdog_time_q != 3'h0;
	wire wd_expire = wd_on && tick_q && wd_cnt_q + 3'h1 >= comm_watchdog_time_q
		&& !tel_pulse && !comm_timeout_error_o;
	wire want_start = cmd_start || din_rise;
	wire want_stop = cmd_stop || din_fall || cmd_rev;
	wire reject = want_start && locked && !want_stop;

	// two flops before any logic looks at pins
	always_ff @(posedge clk_i) begin
		din_s1_q <= din_start_i;
		din_s2_q <= din_s1_q;
		din_s3_q <= din_s2_q;
		tel_s1_q <= telegram_ok_i;
		tel_s2_q <= tel_s1_q;
		tel_s3_q <= tel_s2_q;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_q <= 32'h0000_0000;
			tick_q <= 1'b0;
		end else if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
			tick_cnt_q <= 32'h0000_0000;
			tick_q <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
			tick_q <= 1'b0;
		end
	end

	// register writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			start_interval_time_q <= 10'h000;
			decel_ramp_time_q <= 16'h0000;
			comm_watchdog_time_q <= 3'h0;
			watchdog_action_select_q <= `SLW_ACT_RST;
			irq_en_q <= 3'h0;
		end else if (wb_wr) begin
			if (wb_adr_i == `SLW_ADDR_CTRL) begin
				if (wb_sel_i[0] && wb_sel_i[1]) begin
					// out-of-range settings saturate at the maximum
					if (wb_dat_i[9:0] > `SLW_INTV_MAX) begin
						start_interval_time_q <= `SLW_INTV_MAX;
					end else begin
						start_interval_time_q <= wb_dat_i[9:0];
					end
				end
				if (wb_sel_i[2] && wb_sel_i[3]) begin
					decel_ramp_time_q <= wb_dat_i[31:16];
				end
			end
			if (wb_adr_i == `SLW_ADDR_WDOG && wb_sel_i[0]) begin
				if (wb_dat_i[2:0] > `SLW_WDOG_MAX) begin
					comm_watchdog_time_q <= `SLW_WDOG_MAX;
				end else begin
					comm_watchdog_time_q <= wb_dat_i[2:0];
				end
				if (wb_dat_i[5:4] != 2'h0) begin
					watchdog_action_select_q <= wb_dat_i[5:4];
				end
			end
			if (wb_adr_i == `SLW_ADDR_IRQ_EN && wb_sel_i[0]) begin
				irq_en_q <= wb_dat_i[2:0];
			end
		end
	end

	// motor command sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= slw_pkg::SLW_ST_IDLE;
			motor_run_o <= 1'b0;
			motor_dir_o <= 1'b0;
			jog_o <= 1'b0;
			ramp_stop_o <= 1'b0;
			coast_stop_o <= 1'b0;
			emerg_disable_o <= 1'b0;
			intv_cnt_q <= 10'h000;
		end else begin
			ramp_stop_o <= 1'b0;
			coast_stop_o <= 1'b0;
			jog_o <= cmd_jog && !emerg_disable_o;
			if (tick_q && intv_cnt_q != 10'h3ff) begin
				intv_cnt_q <= intv_cnt_q + 10'h001;
			end
			if (tel_pulse) begin
				emerg_disable_o <= 1'b0;
			end
			if (wd_expire) begin
				unique case (watchdog_action_select_q)
					slw_pkg::SLW_ACT_RAMP: begin
						if (motor_run_o) begin
							motor_run_o <= 1'b0;
							intv_cnt_q <= 10'h000;
							ramp_stop_o <= decel_ramp_time_q != 16'h0000;
							coast_stop_o <= decel_ramp_time_q == 16'h0000;
						end
					end
					slw_pkg::SLW_ACT_EMERG: begin
						motor_run_o <= 1'b0;
						intv_cnt_q <= 10'h000;
						coast_stop_o <= 1'b1;
						emerg_disable_o <= 1'b1;
					end
					default: begin
					end
				endcase
			end else if (want_stop && motor_run_o) begin
				motor_run_o <= 1'b0;
				intv_cnt_q <= 10'h000;
				ramp_stop_o <= decel_ramp_time_q != 16'h0000;
				coast_stop_o <= decel_ramp_time_q == 16'h0000;
				if (cmd_rev) begin
					motor_dir_o <= !motor_dir_o;
					state_q <= slw_pkg::SLW_ST_LOCK;
				end else begin
					state_q <= slw_pkg::SLW_ST_IDLE;
				end
			end else if (cmd_rev && !motor_run_o) begin
				motor_dir_o <= !motor_dir_o;
			end else begin
				unique case (state_q)
					slw_pkg::SLW_ST_IDLE: begin
						if (want_start && !locked && !emerg_disable_o) begin
							motor_run_o <= 1'b1;
							state_q <= slw_pkg::SLW_ST_RUN;
						end
					end
					slw_pkg::SLW_ST_LOCK: begin
						// reversal restarts by itself once interval elapses
						if (!locked && !emerg_disable_o) begin
							motor_run_o <= 1'b1;
							state_q <= slw_pkg::SLW_ST_RUN;
						end
					end
					slw_pkg::SLW_ST_RUN: begin
						if (!motor_run_o) begin
							state_q <= slw_pkg::SLW_ST_IDLE;
						end
					end
				endcase
			end
		end
	end

	// watchdog counter and error flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wd_cnt_q <= 3'h0;
			comm_timeout_error_o <= 1'b0;
		end else if (!wd_on || tel_pulse) begin
			wd_cnt_q <= 3'h0;
			comm_timeout_error_o <= 1'b0;
		end else if (wd_expire) begin
			comm_timeout_error_o <= 1'b1;
		end else if (tick_q && !comm_timeout_error_o) begin
			wd_cnt_q <= wd_cnt_q + 3'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			start_locked_o <= 1'b0;
		end else begin
			start_locked_o <= locked;
		end
	end

	always_comb begin
		irq_clr = 3'h0;
		irq_set = 3'h0;
		if (wb_wr && wb_adr_i == `SLW_ADDR_IRQ_CLR && wb_sel_i[0]) begin
			irq_clr = wb_dat_i[2:0];
		end
		irq_set[`SLW_IRQ_TIMEOUT] = wd_expire;
		irq_set[`SLW_IRQ_REJECT] = reject;
		irq_set[`SLW_IRQ_RECOVER] = tel_pulse && comm_timeout_error_o;
	end

	// set wins over clear on the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_q <= 3'h0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_stat_q & irq_en_q);
		end
	end

	// one wait state, ack drops the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h0000_0000;
			if (wb_req && !wb_we_i) begin
				unique case (wb_adr_i)
					`SLW_ADDR_CTRL: wb_dat_o <= {decel_ramp_time_q, 6'h00, start_interval_time_q};
					`SLW_ADDR_WDOG: wb_dat_o <= {26'h0, watchdog_action_select_q, 1'b0,
						comm_watchdog_time_q};
					`SLW_ADDR_STAT: wb_dat_o <= {13'h0000, intv_cnt_q, 1'b0, wd_cnt_q,
						emerg_disable_o, comm_timeout_error_o, locked, motor_dir_o,
						motor_run_o};
					`SLW_ADDR_IRQ_STAT: wb_dat_o <= {29'h0, irq_stat_q};
					`SLW_ADDR_IRQ_EN: wb_dat_o <= {29'h0, irq_en_q};
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	a_lock_blocks_start: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_q == slw_pkg::SLW_ST_IDLE && !motor_run_o && locked) |=> !motor_run_o)
		else $error("start taken during lockout");
	a_stop_clears_intv: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(motor_run_o) |-> intv_cnt_q == 10'h000)
		else $error("interval not restarted at stop");
	a_emerg_coasts: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(emerg_disable_o) |-> coast_stop_o && !motor_run_o)
		else $error("emergency did not coast motor");
	a_error_clears: assert property (@(posedge clk_i) disable iff (rst_i)
		(tel_pulse && comm_watchdog_time_q == $past(comm_watchdog_time_q))
		|=> !comm_timeout_error_o)
		else $error("error not cleared by telegram");
	a_wdog_off_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		!wd_on |=> !comm_timeout_error_o)
		else $error("error raised with watchdog off");
	a_wdog_bound: assert property (@(posedge clk_i) disable iff (rst_i)
		wd_cnt_q <= `SLW_WDOG_MAX)
		else $error("watchdog count out of range");
	a_act1_no_motor: assert property (@(posedge clk_i) disable iff (rst_i)
		(wd_expire && watchdog_action_select_q == slw_pkg::SLW_ACT_FLAG && !want_stop)
		|=> motor_run_o == $past(motor_run_o))
		else $error("action 1 touched the motor");
	a_ramp_choice: assert property (@(posedge clk_i) disable iff (rst_i)
		ramp_stop_o |-> $past(decel_ramp_time_q) != 16'h0000 && !coast_stop_o)
		else $error("ramp stop with ramp time off");
	a_tick_period: assert property (@(posedge clk_i) disable iff (rst_i)
		tick_q |=> !tick_q)
		else $error("tick wider than one cycle");
	a_intv_range: assert property (@(posedge clk_i) disable iff (rst_i)
		start_interval_time_q <= `SLW_INTV_MAX)
		else $error("start interval out of range");
	c_reject: cover property (@(posedge clk_i) reject);
	c_timeout: cover property (@(posedge clk_i) wd_expire);
	c_reverse: cover property (@(posedge clk_i) state_q == slw_pkg::SLW_ST_LOCK);
	c_jog: cover property (@(posedge clk_i) jog_o && locked);
endmodule

// *** rtl/slw_params.svh ***
// constants of the start lockout and comm watchdog block
`ifndef SLW_PARAMS_SVH
`define SLW_PARAMS_SVH
`define SLW_ADDR_CTRL 8'h00
`define SLW_ADDR_WDOG 8'h04
`define SLW_ADDR_CMD 8'h08
`define SLW_ADDR_STAT 8'h0c
`define SLW_ADDR_IRQ_STAT 8'h10
`define SLW_ADDR_IRQ_CLR 8'h14
`define SLW_ADDR_IRQ_EN 8'h18
`define SLW_CTRL_INTV_LSB 0
`define SLW_CTRL_RAMP_LSB 16
`define SLW_WDOG_TIME_LSB 0
`define SLW_WDOG_ACT_LSB 4
`define SLW_INTV_MAX 10'h3e7
`define SLW_WDOG_MAX 3'h5
`define SLW_ACT_RST 2'h1
`define SLW_CMD_START 0
`define SLW_CMD_STOP 1
`define SLW_CMD_JOG 2
`define SLW_CMD_REV 3
`define SLW_CLK_HZ 100000000
`define SLW_TICK_S 1
`define SLW_TICK_CYC (`SLW_CLK_HZ * `SLW_TICK_S)
`define SLW_IRQ_TIMEOUT 0
`define SLW_IRQ_REJECT 1
`define SLW_IRQ_RECOVER 2
`endif

// *** rtl/slw_pkg.sv ***
// types of the start lockout and comm watchdog block
package slw_pkg;
	typedef enum logic [1:0] {
		SLW_ACT_NONE,
		SLW_ACT_FLAG,
		SLW_ACT_RAMP,
		SLW_ACT_EMERG
	} slw_action_t;
	typedef enum {
		SLW_ST_IDLE,
		SLW_ST_RUN,
		SLW_ST_LOCK
	} slw_state_t;
endpackage

// *** testbench/slw_master_model.sv ***
// serial master model sending cyclic telegram pulses
`timescale 1ns/1ps
module slw_master_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	input wire logic [7:0] gap_i,
	output logic telegram_o
);
	logic [7:0] cnt_q;
	// three cycles high so the pin synchroniser cannot miss it
	always_ff @(posedge clk_i) begin
		if (rst_i || !en_i) begin
			cnt_q <= 8'h00;
			telegram_o <= 1'b0;
		end else begin
			cnt_q <= (cnt_q >= gap_i) ? 8'h00 : cnt_q + 8'h01;
			telegram_o <= (cnt_q < 8'h03);
		end
	end
endmodule

// *** testbench/test_slw_top.sv ***
// self-checking bench of the start lockout and comm watchdog block
`timescale 1ns/1ps
`include "slw_params.svh"
module test_slw_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic din = 1'b0;
	logic men = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [7:0] gap = 8'h08;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rd, wdo, v;
	logic [31:0] seed = 32'h53b1;
	logic [1:0] stp = 2'h0;
	logic stp_clr = 1'b0;
	logic ack, run, dir, jog, rstop, cstop, emg, err, lck, irq, tel;
	logic [6:0] ov;
	int fail_count = 0;
	int check_count = 0;
	assign ov = {jog, irq, lck, err, emg, dir, run};
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) stp <= stp_clr ? 2'h0 : (stp | {rstop, cstop});
	slw_top #(.TICK_CYCLES(20)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(wdo), .wb_ack_o(ack), .din_start_i(din), .telegram_ok_i(tel),
		.motor_run_o(run), .motor_dir_o(dir), .jog_o(jog), .ramp_stop_o(rstop),
		.coast_stop_o(cstop), .emerg_disable_o(emg), .comm_timeout_error_o(err),
		.start_locked_o(lck), .irq_o(irq)
	);
	slw_master_model mst (.clk_i(clk_i), .rst_i(rst_i), .en_i(men), .gap_i(gap),
		.telegram_o(tel));
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function logic [31:0] exp_ctrl(input logic [31:0] x);
		return {x[31:16], 6'h00, (x[9:0] > `SLW_INTV_MAX) ? `SLW_INTV_MAX : x[9:0]};
	endfunction
	function logic [31:0] exp_wdog(input logic [31:0] x);
		return {26'h0, x[5:4], 1'b0, (x[2:0] > `SLW_WDOG_MAX) ? `SLW_WDOG_MAX : x[2:0]};
	endfunction
	task finish_test;
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task co(input int b, input logic x);
		chk({31'h0, ov[b]}, {31'h0, x});
	endtask
	// one classic cycle; ack is taken at the edge it is seen
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			fail_count++;
			finish_test();
		end
		rd = wdo;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task wt(input int b, input logic x, input int lim);
		int n;
		n = 0;
		while (ov[b] !== x && n < lim) begin
			@(posedge clk_i);
			n++;
		end
		co(b, x);
		if (n >= lim)
			finish_test();
	endtask
	initial begin
		repeat (100000) @(posedge clk_i);
		fail_count++;
		finish_test();
	end
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, `SLW_ADDR_CTRL, 0); chk(rd, 0);
		wb(0, `SLW_ADDR_WDOG, 0); chk(rd, 32'h10);
		wb(0, `SLW_ADDR_STAT, 0); chk(rd, 0);
		wb(0, 8'h1c, 0); chk(rd, 0);
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 32'h3e8 : rnd();
			wb(1, `SLW_ADDR_CTRL, v);
			wb(0, `SLW_ADDR_CTRL, 0); chk(rd, exp_ctrl(v));
			v = rnd() & 32'h37;
			v[4] = v[4] | ~v[5];
			wb(1, `SLW_ADDR_WDOG, v);
			wb(0, `SLW_ADDR_WDOG, 0); chk(rd, exp_wdog(v));
		end
		wb(1, `SLW_ADDR_WDOG, 32'h10);
		// random settings may have latched an emergency and zeroed the interval count
		men <= 1'b1;
		repeat (45) @(posedge clk_i);
		co(2, 0);
		men <= 1'b0;
		wb(1, `SLW_ADDR_IRQ_EN, 7);
		wb(1, `SLW_ADDR_CTRL, 32'h0001_0002);
		wb(1, `SLW_ADDR_CMD, 1); wt(0, 1, 10);
		wb(1, `SLW_ADDR_CMD, 2); wt(4, 1, 10); co(0, 0);
		wb(1, `SLW_ADDR_CMD, 1); repeat (5) @(posedge clk_i); co(0, 0);
		wb(0, `SLW_ADDR_IRQ_STAT, 0); chk(rd & 32'h2, 32'h2);
		wt(5, 1, 5);
		din <= 1'b1;
		repeat (8) @(posedge clk_i); co(0, 0);
		wb(1, `SLW_ADDR_CMD, 4); wt(6, 1, 10);
		din <= 1'b0;
		wt(4, 0, 80);
		din <= 1'b1;
		wt(0, 1, 10);
		wb(1, `SLW_ADDR_CMD, 8); wt(0, 0, 10); wt(4, 1, 5);
		wt(0, 1, 80); co(1, 1); co(4, 0);
		din <= 1'b0;
		wt(0, 0, 10); co(3, 0);
		wb(1, `SLW_ADDR_IRQ_CLR, 7); wt(5, 0, 5);
		// last pass is action 2 with a ramp, to see ramp against coast
		for (int k = 0; k < 4; k++) begin
			gap <= 8'(6 + rnd() % 6);
			men <= 1'b1;
			wb(1, `SLW_ADDR_CTRL, (k == 3) ? 32'h0003_0000 : 0);
			wb(1, `SLW_ADDR_IRQ_EN, (k == 1) ? 0 : 1);
			wb(1, `SLW_ADDR_IRQ_CLR, 7);
			wb(1, `SLW_ADDR_WDOG, ((k == 3 ? 2 : k + 1) << 4) | 2);
			wb(1, `SLW_ADDR_CMD, 1); wt(0, 1, 10);
			repeat (60) @(posedge clk_i); co(3, 0);
			stp_clr <= 1'b1;
			men <= 1'b0;
			@(posedge clk_i);
			stp_clr <= 1'b0;
			wt(3, 1, 80);
			repeat (3) @(posedge clk_i);
			co(0, k == 0);
			co(2, k == 2);
			co(5, k != 1);
			if (k == 1 || k == 3) chk(stp, (k == 3) ? 2 : 1);
			men <= 1'b1;
			wt(3, 0, 20); co(2, 0);
			wb(0, `SLW_ADDR_IRQ_STAT, 0);
			chk(rd & 32'h5, 32'h5);
			wb(1, `SLW_ADDR_CMD, 2); wt(0, 0, 10);
		end
		finish_test();
	end
endmodule
